// file: pkg/plc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// Register byte offsets
`define ADR_MODE 8'h00
`define ADR_CELLCFG 8'h04
`define ADR_PRELOAD 8'h08
`define ADR_STATUS 8'h0c
`define ADR_SECURE 8'h10
`define ADR_VERIFY 8'h14
`define ADR_SIG_ADDR 8'h18
`define ADR_SIG_DATA 8'h1c

// Field positions
`define PRE_MASK_LSB 8
`define STAT_SECURED_BIT 8
`define STAT_BUSY_BIT 9
`define STAT_REFUSED_BIT 10
`define VER_CFG_LSB 8

// Macrocell configuration codes
`define CFG_REG 2'h0
`define CFG_COMB_IO 2'h1
`define CFG_COMB_OUT 2'h2
`define CFG_INPUT 2'h3

// Reset values
`define MODE_RST 3'h4
`define CELLCFG_RST 16'hffff

// Timing
`define CLK_PERIOD_NS 20
`define PUC_TYP_NS 600
`define PUC_MAX_NS 1000
`define PUC_CYCLES ((`PUC_MAX_NS) / (`CLK_PERIOD_NS))

`endif

// file: pkg/plc_pkg.sv
// Types shared by the macrocell block
package plc_pkg;

  typedef enum logic [2:0] {
    MODE_REG = 3'b001,
    MODE_CPX = 3'b010,
    MODE_SMP = 3'b100
  } arch_mode_e;

  typedef enum logic [1:0] {
    PWR_CLEAR = 2'b01,
    PWR_RUN = 2'b10
  } pwr_state_e;

  typedef logic [1:0] cell_cfg_t;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;

endpackage : plc_pkg

// file: rtl/sig_mem.sv
// Small signature memory with registered read data
`timescale 1ns/1ps
module sig_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = mem[addr_i];
  end

  // Storage has no reset: contents are user data
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule : sig_mem

// file: rtl/macrocell_array.sv
// Eight macrocells with power-up clear, preload, security and signature
//
// Summary of operation
// - Power-up clear drives every macrocell register low
// - Programmer preloads each register high or low
// - 64 signature bits always readable
// - Security fuse blocks verify and preload
// - Undriven pins read high through pull-up
// - Each macrocell picks one of four configurations
// - Exactly one of three architecture modes
// - Registered cells use clock pin and enable
// - Dedicated input cell never drives its pin
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "plc_regs.svh"
module macrocell_array #(
  parameter int NCELL = 8,
  parameter int SIG_BYTES = 8
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic PCLK_I,
  input wire logic OE_N_I,
  input wire logic [NCELL-1:0] PIN_I,
  input wire logic [NCELL-1:0] PIN_DRIVEN_I,
  output logic [NCELL-1:0] PIN_O,
  output logic [NCELL-1:0] PIN_OE_O,
  input wire logic [NCELL-1:0] SUM_I,
  input wire logic [NCELL-1:0] PTOE_I,
  output logic [NCELL-1:0] FB_O,
  output logic [NCELL-1:0] REG_FB_O,
  output logic SECURED_O
);

  localparam int SW = 2 * NCELL + 2;
  localparam int CW = 7;
  localparam logic [CW-1:0] PUC_LAST = CW'(`PUC_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] filt;
  logic [SW-1:0] next_filt;
  logic [SW-1:0] raw_pins;

  always_comb begin
    raw_pins = {PCLK_I, OE_N_I, PIN_DRIVEN_I, PIN_I};
    next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));
  end

  // Enable pin resets to inactive, clock pin to low
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1 <= {2'h1, {NCELL{1'b0}}, {NCELL{1'b1}}};
      sync2 <= {2'h1, {NCELL{1'b0}}, {NCELL{1'b1}}};
      sync3 <= {2'h1, {NCELL{1'b0}}, {NCELL{1'b1}}};
      filt <= {2'h1, {NCELL{1'b0}}, {NCELL{1'b1}}};
    end else if (CE_I) begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  logic pclk_f;
  logic pclk_prev;
  logic pclk_rise;
  logic oe_n_f;
  logic [NCELL-1:0] drv_f;
  logic [NCELL-1:0] pin_f;

  always_comb begin
    pclk_f = filt[SW-1];
    oe_n_f = filt[SW-2];
    drv_f = filt[2*NCELL-1:NCELL];
    pin_f = filt[NCELL-1:0];
    pclk_rise = pclk_f & ~pclk_prev;
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up clear sequencer

  plc_pkg::pwr_state_e pwr_state;
  plc_pkg::pwr_state_e next_pwr_state;
  logic [CW-1:0] puc_cnt;
  logic [CW-1:0] next_puc_cnt;

  always_comb begin
    next_pwr_state = pwr_state;
    next_puc_cnt = puc_cnt;
    case (pwr_state)
      plc_pkg::PWR_CLEAR: begin
        if (puc_cnt == PUC_LAST) begin
          next_pwr_state = plc_pkg::PWR_RUN;
        end else begin
          next_puc_cnt = puc_cnt + CW'(1);
        end
      end
      plc_pkg::PWR_RUN: begin
        next_puc_cnt = '0;
      end
      default: begin
        next_pwr_state = plc_pkg::PWR_CLEAR;
        next_puc_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pwr_state <= plc_pkg::PWR_CLEAR;
      puc_cnt <= '0;
      pclk_prev <= 1'b0;
    end else if (CE_I) begin
      pwr_state <= next_pwr_state;
      puc_cnt <= next_puc_cnt;
      pclk_prev <= pclk_f;
    end
  end

  logic busy;
  always_comb begin
    busy = (pwr_state != plc_pkg::PWR_RUN);
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone programming port

  plc_pkg::wb_req_s req;
  logic acc;
  logic wr;
  always_comb begin
    req = '{adr: ADR_I, we: WE_I, sel: SEL_I, dat: DAT_I};
    acc = CYC_I & STB_I & ~ACK_O;
    wr = acc & req.we;
  end

  plc_pkg::arch_mode_e mode;
  plc_pkg::arch_mode_e next_mode;
  logic [2*NCELL-1:0] cellcfg;
  logic [2*NCELL-1:0] next_cellcfg;
  logic [NCELL-1:0] mc;
  logic [NCELL-1:0] next_mc;
  logic secured;
  logic next_secured;
  logic refused;
  logic next_refused;
  logic [2:0] sig_addr;
  logic [2:0] next_sig_addr;
  logic next_ack;
  logic [31:0] next_dat;
  logic [7:0] sig_rdata;
  logic sig_we;
  logic pre_hit;
  logic ver_hit;
  logic refuse_evt;

  always_comb begin
    next_mode = mode;
    next_cellcfg = cellcfg;
    next_secured = secured;
    next_sig_addr = sig_addr;
    next_ack = acc;
    next_dat = '0;
    sig_we = 1'b0;
    pre_hit = wr & (req.adr == `ADR_PRELOAD) & (&req.sel[1:0]);
    ver_hit = acc & ~req.we & (req.adr == `ADR_VERIFY);
    refuse_evt = (pre_hit & (secured | busy)) | (ver_hit & secured);
    if (req.adr == `ADR_MODE) begin
      next_dat = {29'h0, mode};
      if (wr && req.sel[0]) begin
        case (req.dat[2:0])
          3'b001: next_mode = plc_pkg::MODE_REG;
          3'b010: next_mode = plc_pkg::MODE_CPX;
          3'b100: next_mode = plc_pkg::MODE_SMP;
          default: next_mode = mode;
        endcase
      end
    end else if (req.adr == `ADR_CELLCFG) begin
      next_dat = {16'h0, cellcfg};
      if (wr && req.sel[0]) begin
        next_cellcfg[7:0] = req.dat[7:0];
      end
      if (wr && req.sel[1]) begin
        next_cellcfg[15:8] = req.dat[15:8];
      end
    end else if (req.adr == `ADR_STATUS) begin
      next_dat = {21'h0, refused, busy, secured, mc};
    end else if (req.adr == `ADR_SECURE) begin
      next_dat = {31'h0, secured};
      if (wr && req.sel[0] && req.dat[0]) begin
        next_secured = 1'b1;
      end
    end else if (req.adr == `ADR_VERIFY) begin
      if (!secured) begin
        next_dat = {cellcfg, 5'h0, mode, 8'h0};
      end
    end else if (req.adr == `ADR_SIG_ADDR) begin
      next_dat = {29'h0, sig_addr};
      if (wr && req.sel[0]) begin
        next_sig_addr = req.dat[2:0];
      end
    end else if (req.adr == `ADR_SIG_DATA) begin
      next_dat = {24'h0, sig_rdata};
      sig_we = wr & req.sel[0];
    end
    if (!acc || req.we) begin
      next_dat = '0;
    end
    // Set wins over a same-cycle clear
    next_refused = refused;
    if (wr && req.adr == `ADR_STATUS && req.sel[1] &&
        req.dat[`STAT_REFUSED_BIT]) begin
      next_refused = 1'b0;
    end
    if (refuse_evt) begin
      next_refused = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode <= plc_pkg::MODE_SMP;
      cellcfg <= `CELLCFG_RST;
      secured <= 1'b0;
      refused <= 1'b0;
      sig_addr <= '0;
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else if (CE_I) begin
      mode <= next_mode;
      cellcfg <= next_cellcfg;
      secured <= next_secured;
      refused <= next_refused;
      sig_addr <= next_sig_addr;
      ACK_O <= next_ack;
      DAT_O <= next_dat;
    end
  end

  sig_mem #(
    .WIDTH(8),
    .DEPTH(SIG_BYTES),
    .AW(3)
  ) u_sig (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .we_i(sig_we),
    .addr_i(sig_addr),
    .wdata_i(req.dat[7:0]),
    .rdata_o(sig_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Macrocell registers and pin drivers

  plc_pkg::pin_drive_s drive;
  logic [NCELL-1:0] next_fb;
  logic [NCELL-1:0] pre_mask;
  logic pre_ok;

  always_comb begin
    pre_mask = req.dat[`PRE_MASK_LSB +: NCELL];
    pre_ok = pre_hit & ~secured & ~busy;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCELL; gi++) begin : g_cell
      plc_pkg::cell_cfg_t cfg;
      logic reg_cell;
      always_comb begin
        cfg = cellcfg[2*gi +: 2];
        reg_cell = (cfg == `CFG_REG) && (mode == plc_pkg::MODE_REG);
        if (busy) begin
          next_mc[gi] = 1'b0;
        end else if (pre_ok && pre_mask[gi]) begin
          next_mc[gi] = req.dat[gi];
        // Clock edges only counted after clear
        end else if (pclk_rise && reg_cell) begin
          next_mc[gi] = SUM_I[gi];
        end else begin
          next_mc[gi] = mc[gi];
        end
        if (reg_cell) begin
          drive.out[gi] = ~mc[gi];
          drive.oe[gi] = ~oe_n_f;
        end else if (cfg == `CFG_INPUT) begin
          drive.out[gi] = 1'b1;
          drive.oe[gi] = 1'b0;
        end else if (cfg == `CFG_COMB_IO &&
                     mode != plc_pkg::MODE_SMP) begin
          drive.out[gi] = SUM_I[gi];
          drive.oe[gi] = PTOE_I[gi];
        end else begin
          drive.out[gi] = SUM_I[gi];
          drive.oe[gi] = 1'b1;
        end
        if (PIN_OE_O[gi]) begin
          next_fb[gi] = PIN_O[gi];
        end else if (drv_f[gi]) begin
          next_fb[gi] = pin_f[gi];
        end else begin
          next_fb[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Driver starts off so nothing fights the board during clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mc <= '0;
      PIN_O <= '1;
      PIN_OE_O <= '0;
      FB_O <= '1;
      REG_FB_O <= '0;
      SECURED_O <= 1'b0;
    end else if (CE_I) begin
      mc <= next_mc;
      PIN_O <= drive.out;
      PIN_OE_O <= drive.oe;
      FB_O <= next_fb;
      REG_FB_O <= next_mc;
      SECURED_O <= next_secured;
    end
  end

endmodule : macrocell_array

// file: tb/macrocell_array_asserts.sv
// Port checker for the macrocell block
`timescale 1ns/1ps
module macrocell_array_asserts #(
  parameter int NCELL = 8
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic [NCELL-1:0] PIN_DRIVEN_I,
  input wire logic [NCELL-1:0] PIN_OE_O,
  input wire logic [NCELL-1:0] FB_O,
  input wire logic [NCELL-1:0] REG_FB_O,
  input wire logic SECURED_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence req_s;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence rd_s;
    req_s ##0 !WE_I;
  endsequence
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (req_s |=> ACK_O)
    else $error("request not acknowledged next cycle");
  dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside acknowledge");
  unmapped_zero_a: assert property (rd_s ##0 ADR_I > 8'h1f |=> DAT_O == 0)
    else $error("unmapped read not zero");
  fuse_hold_a: assert property (SECURED_O |=> SECURED_O)
    else $error("security fuse dropped");
  verify_lock_a: assert property (
    rd_s ##0 ADR_I == 8'h14 && SECURED_O |=> DAT_O == 32'h0)
    else $error("verify readable while secured");
  clear_hold_a: assert property (
    $rose(RSTN_I) |-> (REG_FB_O == 0)[*8])
    else $error("registers not cleared after power-up");
  pullup_high_a: assert property (
    (PIN_DRIVEN_I == 0 && PIN_OE_O == 0)[*6] |-> FB_O == '1)
    else $error("undriven pins not seen high");
endmodule : macrocell_array_asserts
////////////////////////////////////////////////////////////////////////////////
bind macrocell_array macrocell_array_asserts #(.NCELL(NCELL))
  macrocell_array_asserts_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .PIN_DRIVEN_I(PIN_DRIVEN_I), .PIN_OE_O(PIN_OE_O), .FB_O(FB_O),
  .REG_FB_O(REG_FB_O), .SECURED_O(SECURED_O));

// file: tb/board_model.sv
// Board side model: clock pin, enable pin and pad drivers
`timescale 1ns/1ps
module board_model (
  input wire logic clk_i,
  output logic pclk_o,
  output logic oe_n_o,
  output logic [7:0] pin_o,
  output logic [7:0] drv_o
);
  logic [7:0] val;
  initial begin
    pclk_o = 1'b0;
    oe_n_o = 1'b1;
    val = 8'h00;
    drv_o = 8'h00;
  end
  // Released pads show the inverse, never a stale copy
  assign pin_o = (val & drv_o) | (~val & ~drv_o);
  // both phases outlast the input filter
  task automatic pulse();
    pclk_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    pclk_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulse
  task automatic pads(input logic [7:0] v, input logic [7:0] d,
                      input logic n);
    val <= v;
    drv_o <= d;
    oe_n_o <= n;
  endtask : pads
endmodule : board_model

// file: tb/macrocell_array_tb.sv
// Self-checking bench for the macrocell block
`timescale 1ns/1ps
`include "plc_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module macrocell_array_tb;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, sum = 8'h00, ptoe = 8'hff;
  logic [7:0] pin_o, oe, fb, regfb, pin, drv;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic ack, sec, pclk, oe_n, ce = 1'b1;
  int n_fail = 0, check_count = 0;
  always #10 clk = ~clk;
  macrocell_array macrocell_array_i (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
    .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .PCLK_I(pclk), .OE_N_I(oe_n),
    .PIN_I(pin), .PIN_DRIVEN_I(drv), .PIN_O(pin_o), .PIN_OE_O(oe),
    .SUM_I(sum), .PTOE_I(ptoe), .FB_O(fb), .REG_FB_O(regfb),
    .SECURED_O(sec));
  board_model board_model_i (.clk_i(clk), .pclk_o(pclk), .oe_n_o(oe_n),
    .pin_o(pin), .drv_o(drv));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      complete_run();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic t_clear();
    `CHK("pin_o", 8'hff, pin_o)
    wb(1'b1, `ADR_PRELOAD, 32'hffff);
    wb(1'b0, `ADR_STATUS, 32'h0);
    `CHK("status", 32'h600, q)
    wb(1'b1, `ADR_STATUS, 32'h400);
    wb(1'b0, `ADR_VERIFY, 32'h0);
    `CHK("verify", 32'hffff0400, q)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    repeat (`PUC_CYCLES) @(posedge clk);
    wb(1'b0, `ADR_STATUS, 32'h0);
    `CHK("status", 32'h0, q)
  endtask : t_clear
  task automatic t_regs();
    board_model_i.pads(8'h00, 8'h00, 1'b0);
    wb(1'b1, `ADR_MODE, 32'h1);
    wb(1'b1, `ADR_CELLCFG, 32'h0);
    repeat (6) @(posedge clk);
    `CHK("pin_o", 8'hff, pin_o)
    `CHK("pin_oe", 8'hff, oe)
    wb(1'b1, `ADR_PRELOAD, 32'hff3c);
    wb(1'b1, `ADR_PRELOAD, 32'h0f00);
    wb(1'b0, `ADR_STATUS, 32'h0);
    `CHK("preload", 32'h30, q)
    `CHK("pin_o", 8'hcf, pin_o)
    sum <= 8'h5a;
    board_model_i.pulse();
    `CHK("reg_fb", 8'h5a, regfb)
    `CHK("pin_o", 8'ha5, pin_o)
    board_model_i.pads(8'h00, 8'h00, 1'b1);
    repeat (6) @(posedge clk);
    `CHK("pin_oe", 8'h00, oe)
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `ADR_MODE, 32'h1 << i);
      wb(1'b0, `ADR_VERIFY, 32'h0);
      `CHK("verify", 32'h100 << i, q)
    end
  endtask : t_regs
  task automatic t_cells();
    logic [1:0] c;
    wb(1'b1, `ADR_MODE, 32'h1);
    board_model_i.pads(8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wb(1'b1, `ADR_CELLCFG, {16'h0, {8{c}}});
      repeat (6) @(posedge clk);
      `CHK("pin_oe", (c == `CFG_INPUT) ? 8'h00 : 8'hff, oe)
    end
    `CHK("fb", 8'hff, fb)
    // Clock enable low: pads change but nothing may move
    ce <= 1'b0;
    board_model_i.pads(8'h00, 8'hff, 1'b0);
    repeat (6) @(posedge clk);
    `CHK("fb_frozen", 8'hff, fb)
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("fb", 8'h00, fb)
  endtask : t_cells
  task automatic t_secure();
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, `ADR_SIG_ADDR, 32'(i));
      wb(1'b1, `ADR_SIG_DATA, 32'(8'ha0 + i));
    end
    wb(1'b1, `ADR_SECURE, 32'h1);
    `CHK("secured", 1'b1, sec)
    wb(1'b0, `ADR_VERIFY, 32'h0);
    `CHK("verify", 32'h0, q)
    wb(1'b1, `ADR_PRELOAD, 32'hff00);
    wb(1'b0, `ADR_STATUS, 32'h0);
    `CHK("status", 32'h55a, q)
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, `ADR_SIG_ADDR, 32'(i));
      wb(1'b0, `ADR_SIG_DATA, 32'h0);
      `CHK("signature", 8'(8'ha0 + i), q[7:0])
    end
  endtask : t_secure
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_clear();
    t_regs();
    t_cells();
    t_secure();
    complete_run();
  end
endmodule : macrocell_array_tb
